// ==== rtl/instr_regmap_pkg.sv ====
// Constants for the instrument register map: function codes, register
// addresses, status bit positions and reset values.
// Assumes the link framing and checksum are handled upstream; only decoded
// register requests reach this block.
// Operation
// RULE_01 - status bit0 standby, bit1 output active
// RULE_02 - bits 4,5,6,8 trips; bit7 sense loss
// RULE_03 - bit9 set during internal shutdown condition
// RULE_04 - bit10 linear stage, bit11 resistor overpower
// RULE_05 - bit12 boot failed, bit13 boot pending
// RULE_06 - bit17 overvoltage, bit16 overcurrent product rating
// RULE_07 - bit19 aux fuse, bit33 input fuse
// RULE_08 - bit29 out of regulation, unexpected currents
// RULE_09 - bit32 one or more phases missing
// RULE_10 - bit34 fan stall, bits36-39 overheat faults
// RULE_11 - single write of 1/0 switches output
// RULE_12 - output state reads 1 only when active
// RULE_13 - two-register read returns averaged current float
// RULE_14 - voltage read, sense voltage when sensing engaged
// RULE_15 - two-register read returns averaged power float
// RULE_16 - current target written, read back paired
// RULE_17 - voltage target written, read back paired
// RULE_18 - power target written, read back paired
// RULE_19 - sustained overcurrent disconnects, raises current trip
// RULE_20 - sustained overvoltage disconnects, raises voltage trip
// RULE_21 - sustained overpower disconnects, raises power trip
// RULE_22 - status read as four registers, never clears
// RULE_23 - master accesses one value per request
// RULE_24 - high word first, halves updated together
package instr_regmap_pkg;
  // function codes
  localparam logic [7:0] FC_READ = 8'h03;
  localparam logic [7:0] FC_WRITE_ONE = 8'h06;
  localparam logic [7:0] FC_WRITE_MANY = 8'h10;
  // exception codes
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_BAD_FUNC = 8'h01;
  localparam logic [7:0] EXC_BAD_ADDR = 8'h02;
  localparam logic [7:0] EXC_BAD_VALUE = 8'h03;
  // register counts
  localparam logic [15:0] CNT_WORD = 16'h0001;
  localparam logic [15:0] CNT_FLOAT = 16'h0002;
  localparam logic [15:0] CNT_STATUS = 16'h0004;
  // addresses
  localparam logic [15:0] ADDR_STATUS = 16'h10D0;
  localparam logic [15:0] ADDR_OUT_WRITE = 16'h10F0;
  localparam logic [15:0] ADDR_OUT_READ = 16'h1100;
  localparam logic [15:0] ADDR_MEAS_CURR = 16'h2010;
  localparam logic [15:0] ADDR_MEAS_VOLT = 16'h2020;
  localparam logic [15:0] ADDR_MEAS_PWR = 16'h2030;
  localparam logic [15:0] ADDR_CURR_TGT_W = 16'h3010;
  localparam logic [15:0] ADDR_CURR_TGT_R = 16'h3020;
  localparam logic [15:0] ADDR_VOLT_TGT_W = 16'h3030;
  localparam logic [15:0] ADDR_VOLT_TGT_R = 16'h3040;
  localparam logic [15:0] ADDR_PWR_TGT_W = 16'h3050;
  localparam logic [15:0] ADDR_PWR_TGT_R = 16'h3060;
  localparam logic [15:0] ADDR_CURR_LIM_W = 16'h4010;
  localparam logic [15:0] ADDR_CURR_LIM_R = 16'h4020;
  localparam logic [15:0] ADDR_VOLT_LIM_W = 16'h4030;
  localparam logic [15:0] ADDR_VOLT_LIM_R = 16'h4040;
  localparam logic [15:0] ADDR_PWR_LIM_W = 16'h4050;
  localparam logic [15:0] ADDR_PWR_LIM_R = 16'h4060;
  // output write values
  localparam logic [15:0] OUT_OFF = 16'h0000;
  localparam logic [15:0] OUT_ON = 16'h0001;
  // status bit positions used by this block
  localparam int BIT_STANDBY = 0;
  localparam int BIT_LIVE = 1;
  localparam int BIT_CURR_TRIP = 4;
  localparam int BIT_VOLT_TRIP = 5;
  localparam int BIT_PWR_TRIP = 6;
  localparam int BIT_SHUTDOWN = 9;
  // status bits taken straight from the fault pins
  localparam logic [63:0] PIN_FAULT_MASK = 64'h0000_00F7_200B_3F80;
  // quantity index for the three trip channels
  localparam int Q_CURR = 0;
  localparam int Q_VOLT = 1;
  localparam int Q_PWR = 2;
  localparam int NUM_Q = 3;
  // reset values
  localparam logic [31:0] FLOAT_ZERO = 32'h0000_0000;
  localparam logic [31:0] LIMIT_RESET = 32'h7F80_0000; // +inf, never trips
  localparam int TRIP_SAMPLES_DEF = 3;
endpackage

// ==== rtl/instr_regmap.sv ====
// Register bank of a programmable DC power instrument, reached by decoded
// register requests (read, write single, write multiple).
// Assumes a link front end delivers one request per pulse on the same clock,
// measurement averages arrive on the same clock with a sample strobe, and
// fault flags arrive asynchronously on pins.
`timescale 1ns/1ps
`default_nettype none
module instr_regmap
  import instr_regmap_pkg::*;
#(
  parameter int TRIP_SAMPLES = instr_regmap_pkg::TRIP_SAMPLES_DEF,
  parameter int TRIP_CNT_W = 4
) (
  // clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  // decoded register request
  input wire logic REQ_VALID_IN,
  input wire logic [7:0] REQ_FUNC_IN,
  input wire logic [15:0] REQ_ADDR_IN,
  input wire logic [15:0] REQ_COUNT_IN,
  input wire logic [31:0] REQ_DATA_IN,
  // register answer
  output logic RSP_VALID_OUT,
  output logic [7:0] RSP_EXC_OUT,
  output logic [63:0] RSP_DATA_OUT,
  // averaged measurements, same clock
  input wire logic SAMPLE_STB_IN,
  input wire logic [31:0] MEAS_CURR_IN,
  input wire logic [31:0] MEAS_PWR_IN,
  input wire logic [31:0] MEAS_VOLT_TERM_IN,
  input wire logic [31:0] MEAS_VOLT_SENSE_IN,
  input wire logic SENSE_ENGAGED_IN,
  // asynchronous fault pins, placed at status positions
  input wire logic [63:0] FAULT_PINS_IN,
  // regulation loop side
  output logic OUTPUT_ACTIVE_OUT,
  output logic [31:0] CURRENT_TARGET_OUT,
  output logic [31:0] VOLTAGE_TARGET_OUT,
  output logic [31:0] POWER_TARGET_OUT
);
  import instr_regmap_pkg::*;

  // true when float a is strictly above float b (NaN not handled)
  function automatic logic float_gt(input logic [31:0] a, input logic [31:0] b);
    logic res;
    res = 1'b0;
    if (a[31] != b[31])
      res = !a[31] && ((a[30:0] != 31'h0) || (b[30:0] != 31'h0));
    else if (!a[31])
      res = a[30:0] > b[30:0];
    else
      res = a[30:0] < b[30:0];
    return res;
  endfunction

  localparam logic [TRIP_CNT_W-1:0] TRIP_CNT_MAX = TRIP_CNT_W'(TRIP_SAMPLES);
  localparam logic [TRIP_CNT_W-1:0] TRIP_CNT_ONE = TRIP_CNT_W'(1);

  // fault pin synchroniser, second stage is the only reader of the first
  logic [63:0] fault_meta_r;
  logic [63:0] fault_sync_r;
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      fault_meta_r <= 64'h0;
      fault_sync_r <= 64'h0;
    end else begin
      fault_meta_r <= FAULT_PINS_IN;
      fault_sync_r <= fault_meta_r;
    end
  end

  // control and value state
  logic enable_r, enable_nxt;
  logic [NUM_Q-1:0] trip_r, trip_nxt;
  logic [TRIP_CNT_W-1:0] trip_cnt_r [NUM_Q];
  logic [TRIP_CNT_W-1:0] trip_cnt_nxt [NUM_Q];
  logic [31:0] target_r [NUM_Q];
  logic [31:0] target_nxt [NUM_Q];
  logic [31:0] limit_r [NUM_Q];
  logic [31:0] limit_nxt [NUM_Q];
  logic [31:0] meas_r [NUM_Q];
  logic [31:0] meas_nxt [NUM_Q];
  logic rsp_valid_r, rsp_valid_nxt;
  logic [7:0] rsp_exc_r, rsp_exc_nxt;
  logic [63:0] rsp_data_r, rsp_data_nxt;

  // live status word; shutdown also blocks the output
  logic shutdown;
  logic active;
  logic [63:0] status;
  assign shutdown = fault_sync_r[BIT_SHUTDOWN]; // RULE_03
  assign active = enable_r && (trip_r == '0) && !shutdown; // RULE_12
  always_comb begin
    status = fault_sync_r & PIN_FAULT_MASK; // RULE_02 RULE_04 RULE_05 RULE_06 RULE_07
    status[BIT_STANDBY] = !active; // RULE_01
    status[BIT_LIVE] = active; // RULE_01
    status[BIT_CURR_TRIP] = trip_r[Q_CURR]; // RULE_02
    status[BIT_VOLT_TRIP] = trip_r[Q_VOLT]; // RULE_02
    status[BIT_PWR_TRIP] = trip_r[Q_PWR]; // RULE_02
  end
  // RULE_08 RULE_09 RULE_10 bits 29, 32-34, 36-39 pass through the pin mask above

  // request decode
  logic is_read, is_wone, is_wmany;
  assign is_read = REQ_VALID_IN && (REQ_FUNC_IN == FC_READ);
  assign is_wone = REQ_VALID_IN && (REQ_FUNC_IN == FC_WRITE_ONE);
  assign is_wmany = REQ_VALID_IN && (REQ_FUNC_IN == FC_WRITE_MANY);

  // read data and its exception, one value per request
  logic [63:0] rd_data;
  logic [7:0] rd_exc;
  logic [15:0] rd_cnt;
  always_comb begin
    rd_data = 64'h0;
    rd_cnt = CNT_FLOAT;
    rd_exc = EXC_NONE;
    unique case (REQ_ADDR_IN)
      ADDR_STATUS: begin
        rd_data = status; // RULE_22
        rd_cnt = CNT_STATUS; // RULE_22
      end
      ADDR_OUT_READ: begin
        rd_data = {63'h0, active}; // RULE_12
        rd_cnt = CNT_WORD;
      end
      ADDR_MEAS_CURR: rd_data = {32'h0, meas_r[Q_CURR]}; // RULE_13
      ADDR_MEAS_VOLT: rd_data = {32'h0, meas_r[Q_VOLT]}; // RULE_14
      ADDR_MEAS_PWR: rd_data = {32'h0, meas_r[Q_PWR]}; // RULE_15
      ADDR_CURR_TGT_R: rd_data = {32'h0, target_r[Q_CURR]}; // RULE_16
      ADDR_VOLT_TGT_R: rd_data = {32'h0, target_r[Q_VOLT]}; // RULE_17
      ADDR_PWR_TGT_R: rd_data = {32'h0, target_r[Q_PWR]}; // RULE_18
      ADDR_CURR_LIM_R: rd_data = {32'h0, limit_r[Q_CURR]}; // RULE_19
      ADDR_VOLT_LIM_R: rd_data = {32'h0, limit_r[Q_VOLT]}; // RULE_20
      ADDR_PWR_LIM_R: rd_data = {32'h0, limit_r[Q_PWR]}; // RULE_21
      default: rd_exc = EXC_BAD_ADDR;
    endcase
    // a count that does not span exactly one value is refused
    if (rd_exc == EXC_NONE && REQ_COUNT_IN != rd_cnt) begin
      rd_exc = EXC_BAD_VALUE; // RULE_23
      rd_data = 64'h0;
    end
  end

  // multi-register write target: which bank and which quantity
  logic wm_hit_tgt, wm_hit_lim;
  logic [1:0] wm_q;
  always_comb begin
    wm_hit_tgt = 1'b0;
    wm_hit_lim = 1'b0;
    wm_q = 2'(Q_CURR);
    unique case (REQ_ADDR_IN)
      ADDR_CURR_TGT_W: wm_hit_tgt = 1'b1;
      ADDR_VOLT_TGT_W: begin
        wm_hit_tgt = 1'b1;
        wm_q = 2'(Q_VOLT);
      end
      ADDR_PWR_TGT_W: begin
        wm_hit_tgt = 1'b1;
        wm_q = 2'(Q_PWR);
      end
      ADDR_CURR_LIM_W: wm_hit_lim = 1'b1;
      ADDR_VOLT_LIM_W: begin
        wm_hit_lim = 1'b1;
        wm_q = 2'(Q_VOLT);
      end
      ADDR_PWR_LIM_W: begin
        wm_hit_lim = 1'b1;
        wm_q = 2'(Q_PWR);
      end
      default: ;
    endcase
  end

  // next state for all registers other than the fault synchroniser, and the answer
  logic wr_on, wr_off, wm_ok;
  logic over;
  always_comb begin
    enable_nxt = enable_r;
    trip_nxt = trip_r;
    trip_cnt_nxt = trip_cnt_r;
    target_nxt = target_r;
    limit_nxt = limit_r;
    meas_nxt = meas_r;
    rsp_valid_nxt = REQ_VALID_IN;
    rsp_exc_nxt = EXC_NONE;
    rsp_data_nxt = 64'h0;
    wr_on = 1'b0;
    wr_off = 1'b0;
    wm_ok = 1'b0;
    over = 1'b0;
    // answers
    if (is_read) begin
      rsp_exc_nxt = rd_exc;
      rsp_data_nxt = rd_data;
    end else if (is_wone) begin
      if (REQ_ADDR_IN != ADDR_OUT_WRITE)
        rsp_exc_nxt = EXC_BAD_ADDR;
      else if (REQ_DATA_IN[15:0] == OUT_ON)
        wr_on = 1'b1; // RULE_11
      else if (REQ_DATA_IN[15:0] == OUT_OFF)
        wr_off = 1'b1; // RULE_11
      else
        rsp_exc_nxt = EXC_BAD_VALUE;
    end else if (is_wmany) begin
      if (!wm_hit_tgt && !wm_hit_lim)
        rsp_exc_nxt = EXC_BAD_ADDR;
      else if (REQ_COUNT_IN != CNT_FLOAT)
        rsp_exc_nxt = EXC_BAD_VALUE; // RULE_23
      else
        wm_ok = 1'b1;
    end else if (REQ_VALID_IN) begin
      rsp_exc_nxt = EXC_BAD_FUNC;
    end
    // both halves land in one cycle, so no read sees a torn value
    if (wm_ok && wm_hit_tgt)
      target_nxt[wm_q] = REQ_DATA_IN; // RULE_16 RULE_17 RULE_18 RULE_24
    if (wm_ok && wm_hit_lim)
      limit_nxt[wm_q] = REQ_DATA_IN; // RULE_19 RULE_20 RULE_21 RULE_24
    // switching on restarts after a trip; off simply drops the output
    if (wr_on) begin
      enable_nxt = 1'b1; // RULE_11
      trip_nxt = '0;
      for (int i = 0; i < NUM_Q; i++)
        trip_cnt_nxt[i] = '0;
    end
    if (wr_off)
      enable_nxt = 1'b0; // RULE_11
    // snapshot measurements whole on the strobe
    if (SAMPLE_STB_IN) begin
      meas_nxt[Q_CURR] = MEAS_CURR_IN; // RULE_13
      meas_nxt[Q_VOLT] = SENSE_ENGAGED_IN ? MEAS_VOLT_SENSE_IN : MEAS_VOLT_TERM_IN; // RULE_14
      meas_nxt[Q_PWR] = MEAS_PWR_IN; // RULE_15
      // consecutive-sample trip check; a trip wins over a restart write
      for (int i = 0; i < NUM_Q; i++) begin
        over = float_gt(meas_nxt[i], limit_r[i]);
        if (!over)
          trip_cnt_nxt[i] = '0;
        else if (trip_cnt_r[i] != TRIP_CNT_MAX)
          trip_cnt_nxt[i] = trip_cnt_r[i] + TRIP_CNT_ONE;
        if (over && (trip_cnt_r[i] + TRIP_CNT_ONE >= TRIP_CNT_MAX)) begin
          trip_nxt[i] = 1'b1; // RULE_19 RULE_20 RULE_21
          enable_nxt = 1'b0; // RULE_19 RULE_20 RULE_21
        end
      end
    end
  end

  // register stage
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      enable_r <= 1'b0;
      trip_r <= '0;
      rsp_valid_r <= 1'b0;
      rsp_exc_r <= EXC_NONE;
      rsp_data_r <= 64'h0;
      for (int i = 0; i < NUM_Q; i++) begin
        trip_cnt_r[i] <= '0;
        target_r[i] <= FLOAT_ZERO;
        limit_r[i] <= LIMIT_RESET;
        meas_r[i] <= FLOAT_ZERO;
      end
    end else begin
      enable_r <= enable_nxt;
      trip_r <= trip_nxt;
      rsp_valid_r <= rsp_valid_nxt;
      rsp_exc_r <= rsp_exc_nxt;
      rsp_data_r <= rsp_data_nxt;
      trip_cnt_r <= trip_cnt_nxt;
      target_r <= target_nxt;
      limit_r <= limit_nxt;
      meas_r <= meas_nxt;
    end
  end

  // outputs
  assign RSP_VALID_OUT = rsp_valid_r;
  assign RSP_EXC_OUT = rsp_exc_r;
  assign RSP_DATA_OUT = rsp_data_r;
  assign OUTPUT_ACTIVE_OUT = active;
  assign CURRENT_TARGET_OUT = target_r[Q_CURR];
  assign VOLTAGE_TARGET_OUT = target_r[Q_VOLT];
  assign POWER_TARGET_OUT = target_r[Q_PWR];
endmodule // instr_regmap
`default_nettype wire

// ==== test/instr_regmap_sva.sv ====
// port-level checker for the instrument register map
// assumes a bind onto instr_regmap from the bench top
`timescale 1ns/1ps
`default_nettype none
module instr_regmap_sva
  import instr_regmap_pkg::*;
(
  // clock, reset, request side, fault pins and sample strobe
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  input wire logic REQ_VALID_IN,
  input wire logic [7:0] REQ_FUNC_IN,
  input wire logic [15:0] REQ_ADDR_IN,
  input wire logic [15:0] REQ_COUNT_IN,
  input wire logic [31:0] REQ_DATA_IN,
  input wire logic [63:0] FAULT_PINS_IN,
  input wire logic SAMPLE_STB_IN,
  // answer and loop side
  input wire logic RSP_VALID_OUT,
  input wire logic [7:0] RSP_EXC_OUT,
  input wire logic [63:0] RSP_DATA_OUT,
  input wire logic OUTPUT_ACTIVE_OUT,
  input wire logic [31:0] CURRENT_TARGET_OUT,
  input wire logic [31:0] VOLTAGE_TARGET_OUT
);
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (RST_IN);
  // request decode, kept apart so each property stays short
  logic out_wr, cur_wr, volt_wr, stat_rd, known_fc;
  assign out_wr = REQ_VALID_IN && REQ_FUNC_IN == FC_WRITE_ONE && REQ_ADDR_IN == ADDR_OUT_WRITE;
  assign cur_wr = REQ_VALID_IN && REQ_FUNC_IN == FC_WRITE_MANY && REQ_ADDR_IN == ADDR_CURR_TGT_W
    && REQ_COUNT_IN == CNT_FLOAT;
  assign volt_wr = REQ_VALID_IN && REQ_FUNC_IN == FC_WRITE_MANY && REQ_ADDR_IN == ADDR_VOLT_TGT_W;
  assign stat_rd = REQ_VALID_IN && REQ_FUNC_IN == FC_READ && REQ_ADDR_IN == ADDR_STATUS;
  assign known_fc = REQ_FUNC_IN inside {FC_READ, FC_WRITE_ONE, FC_WRITE_MANY};
  a_answer_pulse: assert property (RSP_VALID_OUT == $past(REQ_VALID_IN))
    else $error("answer pulse not one cycle after request");
  a_output_on: assert property (out_wr && REQ_DATA_IN[15:0] == OUT_ON && !FAULT_PINS_IN[9]
    && !SAMPLE_STB_IN |=> OUTPUT_ACTIVE_OUT && RSP_EXC_OUT == EXC_NONE)
    else $error("output not switched on");
  a_output_off: assert property (out_wr && REQ_DATA_IN[15:0] == OUT_OFF |=> !OUTPUT_ACTIVE_OUT)
    else $error("output not switched off");
  a_bad_value_held: assert property (out_wr && REQ_DATA_IN[15:1] != 15'h0
    |=> RSP_EXC_OUT == EXC_BAD_VALUE && $stable(OUTPUT_ACTIVE_OUT))
    else $error("bad output value accepted");
  a_state_bits: assert property (stat_rd && REQ_COUNT_IN == CNT_STATUS
    |=> RSP_DATA_OUT[1:0] == {$past(OUTPUT_ACTIVE_OUT), !$past(OUTPUT_ACTIVE_OUT)})
    else $error("standby and live bits wrong");
  a_status_count: assert property (stat_rd && REQ_COUNT_IN != CNT_STATUS
    |=> RSP_EXC_OUT == EXC_BAD_VALUE)
    else $error("status read count not refused");
  a_bad_func: assert property (REQ_VALID_IN && !known_fc |=> RSP_EXC_OUT == EXC_BAD_FUNC)
    else $error("unknown function not refused");
  a_curr_target: assert property (cur_wr |=> CURRENT_TARGET_OUT == $past(REQ_DATA_IN))
    else $error("current target not stored whole");
  a_volt_target_hold: assert property (!volt_wr |=> $stable(VOLTAGE_TARGET_OUT))
    else $error("voltage target moved without a write");
endmodule // instr_regmap_sva
`default_nettype wire

// ==== test/host_model.sv ====
// master model issuing one decoded request at a time
// assumes the answer stands in the cycle after the taking edge
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // clock and answer
  input wire logic clk_in,
  input wire logic rsp_valid_in,
  input wire logic [7:0] rsp_exc_in,
  input wire logic [63:0] rsp_data_in,
  // request
  output logic req_valid_out,
  output logic [7:0] req_func_out,
  output logic [15:0] req_addr_out,
  output logic [15:0] req_count_out,
  output logic [31:0] req_data_out
);
  initial {req_valid_out, req_func_out, req_addr_out, req_count_out, req_data_out} = '0;
  // one value per request; released address and data lines carry junk, not the old value
  task automatic xfer(input logic [7:0] f, input logic [15:0] a, c, input logic [31:0] d,
    output logic ok, output logic [7:0] e, output logic [63:0] r);
    @(posedge clk_in);
    req_valid_out <= 1'b1;
    req_func_out <= f;
    req_addr_out <= a;
    req_count_out <= c;
    req_data_out <= d;
    @(posedge clk_in);
    req_valid_out <= 1'b0;
    req_addr_out <= ~a;
    req_data_out <= ~d;
    #1;
    ok = rsp_valid_in;
    e = rsp_exc_in;
    r = rsp_data_in;
  endtask
endmodule // host_model
`default_nettype wire

// ==== test/instr_regmap_tb.sv ====
// self-checking bench for the instrument register map
// assumes host_model drives requests; bench drives measurements and pins
`timescale 1ns/1ps
`default_nettype none
module instr_regmap_tb;
  import instr_regmap_pkg::*;
  typedef struct packed {
    logic [7:0] f; logic [15:0] a; logic [15:0] c; logic [31:0] d; logic [7:0] e; logic [63:0] r;
  } row_t;
  logic ref_clk, rst, stb, sense, rq_v, rs_v, act;
  logic [7:0] rq_f, rs_e;
  logic [15:0] rq_a, rq_c;
  logic [31:0] rq_d, mi, mp, mvt, mvs, ctgt, vtgt, ptgt;
  logic [63:0] pins, rs_d;
  int fails, samples_checked;
  // ordinary cases: request beside expected exception and read data
  row_t rows [25] = '{
    '{8'h03, 16'h10D0, 16'h2, 32'h0, 8'h3, 64'h0},
    '{8'h03, 16'h4060, 16'h2, 32'h0, 8'h0, 64'h7F80_0000},
    '{8'h10, 16'h3010, 16'h2, 32'h40A0_0000, 8'h0, 64'h0},
    '{8'h03, 16'h3020, 16'h2, 32'h0, 8'h0, 64'h40A0_0000},
    '{8'h10, 16'h3030, 16'h2, 32'h4248_0000, 8'h0, 64'h0},
    '{8'h03, 16'h3040, 16'h2, 32'h0, 8'h0, 64'h4248_0000},
    '{8'h10, 16'h3050, 16'h2, 32'h447A_0000, 8'h0, 64'h0},
    '{8'h03, 16'h3060, 16'h2, 32'h0, 8'h0, 64'h447A_0000},
    '{8'h10, 16'h4010, 16'h2, 32'h3F80_0000, 8'h0, 64'h0},
    '{8'h03, 16'h4020, 16'h2, 32'h0, 8'h0, 64'h3F80_0000},
    '{8'h10, 16'h4030, 16'h2, 32'h4000_0000, 8'h0, 64'h0},
    '{8'h03, 16'h4040, 16'h2, 32'h0, 8'h0, 64'h4000_0000},
    '{8'h03, 16'h3010, 16'h2, 32'h0, 8'h2, 64'h0},
    '{8'h10, 16'h3020, 16'h2, 32'h1, 8'h2, 64'h0},
    '{8'h10, 16'h3010, 16'h1, 32'h1, 8'h3, 64'h0},
    '{8'h03, 16'h2010, 16'h1, 32'h0, 8'h3, 64'h0},
    '{8'h05, 16'h10F0, 16'h1, 32'h1, 8'h1, 64'h0},
    '{8'h03, 16'h5000, 16'h2, 32'h0, 8'h2, 64'h0},
    '{8'h06, 16'h10F0, 16'h1, 32'h2, 8'h3, 64'h0},
    '{8'h06, 16'h10F0, 16'h1, 32'h1, 8'h0, 64'h0},
    '{8'h03, 16'h1100, 16'h1, 32'h0, 8'h0, 64'h1},
    '{8'h03, 16'h10D0, 16'h4, 32'h0, 8'h0, 64'h2},
    '{8'h06, 16'h10F0, 16'h1, 32'h0, 8'h0, 64'h0},
    '{8'h03, 16'h1100, 16'h1, 32'h0, 8'h0, 64'h0},
    '{8'h03, 16'h10D0, 16'h4, 32'h0, 8'h0, 64'h1}};
  host_model u_host_model (.clk_in(ref_clk), .rsp_valid_in(rs_v), .rsp_exc_in(rs_e),
    .rsp_data_in(rs_d), .req_valid_out(rq_v), .req_func_out(rq_f), .req_addr_out(rq_a),
    .req_count_out(rq_c), .req_data_out(rq_d));
  instr_regmap u_instr_regmap (.REF_CLK_IN(ref_clk), .RST_IN(rst), .REQ_VALID_IN(rq_v),
    .REQ_FUNC_IN(rq_f), .REQ_ADDR_IN(rq_a), .REQ_COUNT_IN(rq_c), .REQ_DATA_IN(rq_d),
    .RSP_VALID_OUT(rs_v), .RSP_EXC_OUT(rs_e), .RSP_DATA_OUT(rs_d), .SAMPLE_STB_IN(stb),
    .MEAS_CURR_IN(mi), .MEAS_PWR_IN(mp), .MEAS_VOLT_TERM_IN(mvt), .MEAS_VOLT_SENSE_IN(mvs),
    .SENSE_ENGAGED_IN(sense), .FAULT_PINS_IN(pins), .OUTPUT_ACTIVE_OUT(act),
    .CURRENT_TARGET_OUT(ctgt), .VOLTAGE_TARGET_OUT(vtgt), .POWER_TARGET_OUT(ptgt));
  task automatic chk(string n, logic [63:0] got, logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic end_of_test;
    if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one request; data compared only on accepted reads
  task automatic req(logic [7:0] f, logic [15:0] a, c, logic [31:0] d, logic [7:0] e,
    logic [63:0] r);
    logic ok;
    logic [7:0] ge;
    logic [63:0] gr;
    u_host_model.xfer(f, a, c, d, ok, ge, gr);
    chk("answer", {63'h0, ok}, 64'h1);
    chk("exception", {56'h0, ge}, {56'h0, e});
    if (f == 8'h03 && e == 8'h00) chk("read data", gr, r);
  endtask
  // one strobe with only channel k above zero
  task automatic smp(logic [31:0] v, int k);
    mi <= (k == 0) ? v : 32'h0;
    mvt <= (k == 1) ? v : 32'h0;
    mvs <= (k == 1) ? v : 32'h0;
    mp <= (k == 2) ? v : 32'h0;
    stb <= 1'b1;
    @(posedge ref_clk);
    stb <= 1'b0;
    @(posedge ref_clk);
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // watchdog sized well beyond the fewer than 200 cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    end_of_test();
  end
  initial begin
    {rst, stb, sense, mi, mp, mvt, mvs, pins} = {3'b100, 192'h0};
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (rows[i]) req(rows[i].f, rows[i].a, rows[i].c, rows[i].d, rows[i].e, rows[i].r);
    chk("voltage target", {32'h0, vtgt}, 64'h4248_0000);
    chk("power target", {32'h0, ptgt}, 64'h447A_0000);
    mi <= 32'h3F00_0000;
    mp <= 32'h4080_0000;
    mvt <= 32'h3FC0_0000;
    mvs <= 32'h3FA0_0000;
    for (int s = 0; s < 2; s++) begin
      sense <= s[0];
      stb <= 1'b1;
      @(posedge ref_clk);
      stb <= 1'b0;
      req(8'h03, 16'h2010, 16'h2, 32'h0, 8'h0, 64'h3F00_0000);
      req(8'h03, 16'h2020, 16'h2, 32'h0, 8'h0, s ? 64'h3FA0_0000 : 64'h3FC0_0000);
    end
    sense <= 1'b0;
    req(8'h03, 16'h2030, 16'h2, 32'h0, 8'h0, 64'h4080_0000);
    pins <= 64'hFFFF_FFFF_FFFF_FDFF;
    repeat (3) @(posedge ref_clk);
    repeat (2) req(8'h03, 16'h10D0, 16'h4, 32'h0, 8'h0, 64'h0000_00F7_200B_3D81);
    pins <= 64'h0;
    req(8'h06, 16'h10F0, 16'h1, 32'h1, 8'h0, 64'h0);
    pins <= 64'h200;
    repeat (3) @(posedge ref_clk);
    chk("active on shutdown", {63'h0, act}, 64'h0);
    req(8'h03, 16'h10D0, 16'h4, 32'h0, 8'h0, 64'h201);
    pins <= 64'h0;
    repeat (3) @(posedge ref_clk);
    // a below-limit sample must restart the consecutive count
    for (int k = 0; k < 2; k++) begin
      req(8'h06, 16'h10F0, 16'h1, 32'h1, 8'h0, 64'h0);
      foreach (rows[j]) if (j < 5) smp((j == 2) ? 32'h0 : 32'h4040_0000, k);
      chk("active before trip", {63'h0, act}, 64'h1);
      smp(32'h4040_0000, k);
      repeat (2) @(posedge ref_clk);
      chk("active after trip", {63'h0, act}, 64'h0);
      req(8'h03, 16'h10D0, 16'h4, 32'h0, 8'h0, 64'h1 | (64'h10 << k));
      smp(32'h0, k);
    end
    rst <= 1'b1;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    chk("current target", {32'h0, ctgt}, 64'h0);
    req(8'h03, 16'h4020, 16'h2, 32'h0, 8'h0, 64'h7F80_0000);
    req(8'h03, 16'h1100, 16'h1, 32'h0, 8'h0, 64'h0);
    end_of_test();
  end
endmodule // instr_regmap_tb
bind instr_regmap instr_regmap_sva u_instr_regmap_sva (.REF_CLK_IN, .RST_IN, .REQ_VALID_IN,
  .REQ_FUNC_IN, .REQ_ADDR_IN, .REQ_COUNT_IN, .REQ_DATA_IN, .FAULT_PINS_IN, .SAMPLE_STB_IN,
  .RSP_VALID_OUT, .RSP_EXC_OUT, .RSP_DATA_OUT, .OUTPUT_ACTIVE_OUT, .CURRENT_TARGET_OUT,
  .VOLTAGE_TARGET_OUT);
`default_nettype wire
